// File: hdl/cmbp_pkg.sv
// Shared constants and types for the transmit message buffer block.
package cmbp_pkg;

    // ==================================================================
    // Bus and buffer geometry
    // ==================================================================
    localparam int unsigned ADDR_W     = 5;   // Register address width.
    localparam int unsigned NUM_TXBUF  = 3;   // Transmit buffers.
    localparam int unsigned IDX_W      = 2;   // Buffer index width.
    localparam int unsigned BUF_BYTES  = 14;  // Bytes per buffer image.

    // ==================================================================
    // Offsets inside the transmit buffer window
    // ==================================================================
    localparam logic [3:0] OFS_IDENT0   = 4'h0;  // Identifier byte 0.
    localparam logic [3:0] OFS_IDENT1   = 4'h1;  // Identifier byte 1.
    localparam logic [3:0] OFS_IDENT2   = 4'h2;  // Identifier byte 2.
    localparam logic [3:0] OFS_IDENT3   = 4'h3;  // Identifier byte 3.
    localparam logic [3:0] OFS_PAYLOAD0 = 4'h4;  // First payload byte.
    localparam logic [3:0] OFS_PAYLOAD7 = 4'hb;  // Last payload byte.
    localparam logic [3:0] OFS_LENGTH   = 4'hc;  // Frame length code.
    localparam logic [3:0] OFS_PRIORITY_VALUE     = 4'hd;  // Local priority.

    // ==================================================================
    // Control registers outside the window
    // ==================================================================
    localparam logic [ADDR_W-1:0] REG_TX_FLAG = 5'h10; // Empty flags.
    localparam logic [ADDR_W-1:0] REG_TX_SEL  = 5'h11; // Buffer select.

    // ==================================================================
    // Field positions
    // ==================================================================
    localparam int unsigned RTR_BIT     = 4;  // Remote flag, byte 1.
    localparam int unsigned IDE_BIT     = 3;  // Extension flag, byte 1.
    localparam int unsigned STD_LO_LSB  = 5;  // Low id bits 7..5.
    localparam int unsigned EXT_RTR_BIT = 0;  // Remote flag, byte 3.
    localparam int unsigned DLC_W       = 4;  // Length code width.
    localparam int unsigned STD_ID_W    = 11; // Standard id width.
    localparam int unsigned EXT_ID_W    = 29; // Extended id width.

    // ==================================================================
    // Values
    // ==================================================================
    localparam logic [DLC_W-1:0] MAX_BYTES  = 4'h8;  // Payload limit.
    localparam logic [7:0]       PRIORITY_VALUE_RESET = 8'h00; // Priority reset.
    localparam logic [7:0]       BYTE_RESET = 8'h00; // Other bytes.

    // Scheduler states, one-hot.
    typedef enum logic [1:0] {
        CMBP_IDLE   = 2'b01,
        CMBP_ACTIVE = 2'b10
    } cmbp_state_type;

endpackage : cmbp_pkg

// File: hdl/cmbp_txbuf.sv
// Storage of one transmit buffer image: identifier, payload, length, priority_value.
`timescale 1ns/1ps
module cmbp_txbuf (
    input  wire logic                 clk_sys_i,  // System clock.
    input  wire logic                 rst_n_i,    // Sync reset, low.
    input  wire logic                 wr_en_i,    // Write this buffer.
    input  wire logic [3:0]           wr_ofs_i,   // Byte offset.
    input  wire logic [7:0]           wr_data_i,  // Byte to store.
    output logic [cmbp_pkg::BUF_BYTES-1:0][7:0] bytes_o // Whole image.
);
    import cmbp_pkg::*;

    // ==================================================================
    // Byte store
    // ==================================================================
    // Every byte is a flip-flop; the priority byte has a documented
    // reset, the rest are cleared too so that nothing starts unknown.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int b = 0; b < BUF_BYTES; b++) begin
                bytes_o[b] <= BYTE_RESET;
            end
            bytes_o[OFS_PRIORITY_VALUE] <= PRIORITY_VALUE_RESET;
        end else if (wr_en_i && (wr_ofs_i <= OFS_PRIORITY_VALUE)) begin
            // Offsets past the priority byte are not stored.
            bytes_o[wr_ofs_i] <= wr_data_i;
        end
    end

endmodule : cmbp_txbuf

// File: hdl/cmbp_priority_value_sel.sv
// Picks the pending buffer with the smallest local priority value.
`timescale 1ns/1ps
module cmbp_priority_value_sel #(
    parameter int unsigned N  = 3,  // Number of buffers.
    parameter int unsigned IW = 2   // Index width.
) (
    input  wire logic [N-1:0]        cand_i,  // Buffers taking part.
    input  wire logic [N-1:0][7:0]   priority_value_i,  // Local priority values.
    output logic                     any_o,   // Some candidate exists.
    output logic [IW-1:0]            win_o    // Winning buffer index.
);
    // ==================================================================
    // Linear search
    // ==================================================================
    // A strict less-than keeps the earlier index on a tie, so the lower
    // numbered buffer wins. Values are compared unsigned.
    logic [7:0] best;  // Smallest value seen so far.

    always_comb begin
        best  = 8'hff;
        any_o = 1'b0;
        win_o = '0;
        for (int i = 0; i < N; i++) begin
            if (cand_i[i] && (!any_o || (priority_value_i[i] < best))) begin
                best  = priority_value_i[i];
                win_o = IW'(i);
                any_o = 1'b1;
            end
        end
    end

endmodule : cmbp_priority_value_sel

// File: hdl/cmbp_top.sv
// Transmit buffers, buffer window, empty flags and local prioritisation.
//
// Contract
// - Standard format uses an 11-bit identifier.
// - Byte0 holds id 10..3, byte1 7..5 id 2..0.
// - Smaller identifier means higher bus priority.
// - Byte1 bit4 is remote flag, sent as is.
// - Byte1 bit3 selects standard or extended id.
// - Eight payload bytes, only length-count ones sent.
// - Length register holds a four-bit length code.
// - Remote frame sends code unchanged, zero bytes.
// - Data frame byte count ranges zero to eight.
// - Pending buffers become candidates just before start.
// - Smallest local priority value wins selection.
// - Equal priorities: lowest buffer index wins.
// - Software clears empty flag; device sets after send.
// - Select register maps one buffer into window.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module cmbp_top (
    input  wire logic                          clk_sys_i,    // Clock.
    input  wire logic                          rst_n_i,      // Reset.
    input  wire logic [cmbp_pkg::ADDR_W-1:0]   addr_i,       // Address.
    input  wire logic [7:0]                    wr_data_i,    // Write data.
    input  wire logic                          wr_i,         // Write.
    input  wire logic                          rd_i,         // Read.
    output logic      [7:0]                    rd_data_o,    // Read data.
    input  wire logic                          tx_sof_i,     // Pre-start.
    input  wire logic                          tx_done_i,    // Sent ok.
    input  wire logic                          tx_abandon_i, // Lost/err.
    input  wire logic [2:0]                    tx_byte_idx_i,// Byte no.
    output logic                               tx_valid_o,   // Frame up.
    output logic      [cmbp_pkg::IDX_W-1:0]    tx_buf_o,     // Buffer.
    output logic      [cmbp_pkg::EXT_ID_W-1:0] tx_id_o,      // Ident.
    output logic                               tx_ide_o,     // Extended.
    output logic                               tx_rtr_o,     // Remote.
    output logic      [cmbp_pkg::DLC_W-1:0]    tx_dlc_o,     // Code.
    output logic      [cmbp_pkg::DLC_W-1:0]    tx_count_o,   // Bytes.
    output logic      [7:0]                    tx_byte_o,    // Payload.
    output logic      [cmbp_pkg::NUM_TXBUF-1:0] tx_empty_o   // Flags.
);
    import cmbp_pkg::*;

    // ==================================================================
    // Declarations
    // ==================================================================
    logic [BUF_BYTES-1:0][7:0] buf_q [NUM_TXBUF]; // Buffer images.
    logic [NUM_TXBUF-1:0][7:0] priority_value_vec;          // Priorities.
    logic [NUM_TXBUF-1:0]      txe_r;             // Empty flags.
    logic [NUM_TXBUF-1:0]      txe_nxt;           // Next flags.
    logic [NUM_TXBUF-1:0]      sel_r;             // One-hot select.
    logic [NUM_TXBUF-1:0]      sel_nxt;           // Next select.
    logic [IDX_W-1:0]          sel_idx;           // Select as index.
    logic                      win_wr;            // Window write ok.
    logic                      win_hit;           // Address in window.
    logic                      arb_any;           // Candidate exists.
    logic [IDX_W-1:0]          arb_win;           // Winning buffer.
    cmbp_state_type            state_r;           // Scheduler state.
    cmbp_state_type            state_nxt;         // Next state.
    logic                      start;             // Selection moment.
    logic [7:0]                rd_mux;            // Read data source.
    logic [EXT_ID_W-1:0]       id_nxt;            // Identifier to send.
    logic                      rtr_nxt;           // Remote flag to send.
    logic                      ide_nxt;           // Format to send.
    logic [DLC_W-1:0]          dlc_nxt;           // Code to send.
    logic [DLC_W-1:0]          cnt_nxt;           // Byte count to send.

    // The window covers the identifier bytes up to the priority byte.
    assign win_hit = (addr_i[ADDR_W-1] == 1'b0) &&
                     (addr_i[3:0] <= OFS_PRIORITY_VALUE);

    // ==================================================================
    // Buffer storage
    // ==================================================================
    // Only the buffer shown in the window can be written, and only
    // while it is empty: a queued buffer is frozen so that what goes
    // on the bus is exactly what was scheduled.
    assign win_wr = wr_i && win_hit && (|(sel_r & txe_r));

    for (genvar k = 0; k < NUM_TXBUF; k++) begin : g_buf
        cmbp_txbuf u_buf (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n_i),
            .wr_en_i   (win_wr && sel_r[k]),
            .wr_ofs_i  (addr_i[3:0]),
            .wr_data_i (wr_data_i),
            .bytes_o   (buf_q[k])
        );
    end
    // Gather the priority bytes for the selector.
    always_comb begin
        for (int k = 0; k < NUM_TXBUF; k++) begin
            priority_value_vec[k] = buf_q[k][OFS_PRIORITY_VALUE];
        end
    end

    // ==================================================================
    // Buffer select register
    // ==================================================================
    // Writing a mask keeps only the lowest set bit that names an empty
    // buffer, so software may offer all empties and take what it gets.
    // A mask with no empty buffer in it unmaps the window.
    always_comb begin
        sel_nxt = sel_r;
        if (wr_i && (addr_i == REG_TX_SEL)) begin
            sel_nxt = '0;
            for (int k = NUM_TXBUF - 1; k >= 0; k--) begin
                if (wr_data_i[k] && txe_r[k]) begin
                    sel_nxt = '0;
                    sel_nxt[k] = 1'b1;
                end
            end
        end
    end
    // Select register update.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sel_r <= '0;
        end else begin
            sel_r <= sel_nxt;
        end
    end
    // Index form of the one-hot select.
    always_comb begin
        sel_idx = '0;
        for (int k = 0; k < NUM_TXBUF; k++) begin
            if (sel_r[k]) begin
                sel_idx = IDX_W'(k);
            end
        end
    end

    // ==================================================================
    // Empty flags
    // ==================================================================
    // Writing a one clears a flag and queues the buffer. A successful
    // send sets the flag of the active buffer; the set wins when both
    // land in the same cycle, so a finished buffer is never lost.
    always_comb begin
        txe_nxt = txe_r;
        if (wr_i && (addr_i == REG_TX_FLAG)) begin
            txe_nxt = txe_r & ~wr_data_i[NUM_TXBUF-1:0];
        end
        if ((state_r == CMBP_ACTIVE) && tx_done_i) begin
            txe_nxt[tx_buf_o] = 1'b1;
        end
    end
    // Flags come out of reset all empty.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            txe_r <= '1;
        end else begin
            txe_r <= txe_nxt;
        end
    end
    // Flags are mirrored to a port from their own flip-flop.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tx_empty_o <= '1;
        end else begin
            tx_empty_o <= txe_nxt;
        end
    end

    // ==================================================================
    // Local prioritisation
    // ==================================================================
    // Candidates are sampled on the pre-start pulse, which the frame
    // engine gives just before the start bit, also after an error.
    cmbp_priority_value_sel #(
        .N  (NUM_TXBUF),
        .IW (IDX_W)
    ) u_sel (
        .cand_i (~txe_r),
        .priority_value_i (priority_value_vec),
        .any_o  (arb_any),
        .win_o  (arb_win)
    );
    // Selection happens only when idle and some buffer is pending.
    assign start = (state_r == CMBP_IDLE) && tx_sof_i && arb_any;
    // Scheduler: idle until a start, active until done or abandon.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CMBP_IDLE: begin
                if (start) begin
                    state_nxt = CMBP_ACTIVE;
                end
            end
            CMBP_ACTIVE: begin
                // A lost or failed frame re-enters selection next time.
                if (tx_done_i || tx_abandon_i) begin
                    state_nxt = CMBP_IDLE;
                end
            end
            default: begin
                state_nxt = CMBP_IDLE;
            end
        endcase
    end
    // State register.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_r <= CMBP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==================================================================
    // Frame header decode of the winning buffer
    // ==================================================================
    // In standard format bytes two and three and the low bits of byte
    // one play no part; the identifier is zero-extended so that a
    // plain numeric compare gives the bus priority, smaller wins.
    always_comb begin
        ide_nxt = buf_q[arb_win][OFS_IDENT1][IDE_BIT];
        dlc_nxt = buf_q[arb_win][OFS_LENGTH][DLC_W-1:0];
        if (ide_nxt) begin
            id_nxt  = {buf_q[arb_win][OFS_IDENT0],
                       buf_q[arb_win][OFS_IDENT1][7:STD_LO_LSB],
                       buf_q[arb_win][OFS_IDENT1][2:0],
                       buf_q[arb_win][OFS_IDENT2],
                       buf_q[arb_win][OFS_IDENT3][7:1]};
            rtr_nxt = buf_q[arb_win][OFS_IDENT3][EXT_RTR_BIT];
        end else begin
            id_nxt  = {{(EXT_ID_W - STD_ID_W){1'b0}},
                       buf_q[arb_win][OFS_IDENT0],
                       buf_q[arb_win][OFS_IDENT1][7:STD_LO_LSB]};
            rtr_nxt = buf_q[arb_win][OFS_IDENT1][RTR_BIT];
        end
        // A remote frame carries no payload whatever its code says.
        if (rtr_nxt) begin
            cnt_nxt = '0;
        end else if (dlc_nxt > MAX_BYTES) begin
            cnt_nxt = MAX_BYTES;
        end else begin
            cnt_nxt = dlc_nxt;
        end
    end
    // Header latch; held for the whole frame since the buffer is frozen.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tx_valid_o <= 1'b0;
            tx_buf_o   <= '0;
            tx_id_o    <= '0;
            tx_ide_o   <= 1'b0;
            tx_rtr_o   <= 1'b0;
            tx_dlc_o   <= '0;
            tx_count_o <= '0;
        end else begin
            tx_valid_o <= (state_nxt == CMBP_ACTIVE);
            if (start) begin
                tx_buf_o   <= arb_win;
                tx_id_o    <= id_nxt;
                tx_ide_o   <= ide_nxt;
                tx_rtr_o   <= rtr_nxt;
                tx_dlc_o   <= dlc_nxt;
                tx_count_o <= cnt_nxt;
            end
        end
    end

    // ==================================================================
    // Payload read port
    // ==================================================================
    // The frame engine asks for byte n and gets it one cycle later; it
    // is expected to ask only below the count it was given.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tx_byte_o <= 8'h00;
        end else begin
            tx_byte_o <= buf_q[tx_buf_o][OFS_PAYLOAD0 +
                                         {1'b0, tx_byte_idx_i}];
        end
    end

    // ==================================================================
    // Register read path
    // ==================================================================
    // An unmapped window or address reads as zero.
    always_comb begin
        rd_mux = 8'h00;
        if (addr_i == REG_TX_FLAG) begin
            rd_mux = {{(8 - NUM_TXBUF){1'b0}}, txe_r};
        end else if (addr_i == REG_TX_SEL) begin
            rd_mux = {{(8 - NUM_TXBUF){1'b0}}, sel_r};
        end else if (win_hit && (|sel_r)) begin
            rd_mux = buf_q[sel_idx][addr_i[3:0]];
        end
    end
    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_i) begin
            rd_data_o <= rd_mux;
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    // ==================================================================
    // Checks
    // ==================================================================
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // Winner is no larger than any candidate, and on ties is lowest.
    logic lo_ok;  // Winner value not above any candidate.
    logic tie_ok; // No lower-index candidate shares the value.
    always_comb begin
        lo_ok  = 1'b1;
        tie_ok = 1'b1;
        for (int j = 0; j < NUM_TXBUF; j++) begin
            if (!txe_r[j] && (priority_value_vec[j] < priority_value_vec[arb_win])) begin
                lo_ok = 1'b0;
            end
            if (!txe_r[j] && (priority_value_vec[j] == priority_value_vec[arb_win]) &&
                (IDX_W'(j) < arb_win)) begin
                tie_ok = 1'b0;
            end
        end
    end

    sequence s_start;
        (state_r == CMBP_IDLE) && tx_sof_i && (txe_r != '1);
    endsequence
    sequence s_done;
        (state_r == CMBP_ACTIVE) && tx_done_i;
    endsequence
    a_priority_value_lowest: assert property (s_start |-> lo_ok && !txe_r[arb_win])
        else $error("winner priority is not the lowest");
    a_priority_value_tie: assert property (s_start |-> tie_ok)
        else $error("tie not resolved to lowest index");
    a_no_cand: assert property ((tx_sof_i && (txe_r == '1) && !tx_valid_o)
                                |=> !tx_valid_o)
        else $error("transmission started with no candidate");
    a_start_valid: assert property (s_start |=> tx_valid_o &&
                                    (tx_buf_o == $past(arb_win)) &&
                                    !tx_empty_o[tx_buf_o])
        else $error("selected frame not presented");
    a_done_sets: assert property (s_done |=> tx_empty_o[$past(tx_buf_o)]
                                  && !tx_valid_o)
        else $error("empty flag not set after send");
    a_remote_zero: assert property (tx_valid_o && tx_rtr_o |->
                                    tx_count_o == 4'h0)
        else $error("remote frame has payload");
    a_count_cap: assert property (tx_valid_o && !tx_rtr_o |->
        tx_count_o == ((tx_dlc_o > 4'h8) ? 4'h8 : tx_dlc_o))
        else $error("payload count wrong");
    a_std_id: assert property (tx_valid_o && !tx_ide_o |->
                               tx_id_o[28:11] == 18'h0)
        else $error("standard id has upper bits");
    a_sel_onehot: assert property ($onehot0(sel_r))
        else $error("window select not one-hot");
    a_priority_value_guard: assert property (wr_i && (addr_i[3:0] == OFS_PRIORITY_VALUE) &&
        win_hit && (sel_r != '0) && !txe_r[sel_idx] |=>
        $stable(priority_value_vec))
        else $error("priority of queued buffer changed");
    a_flag_read: assert property (rd_i && (addr_i == REG_TX_FLAG) |=>
                                  rd_data_o[2:0] == $past(txe_r))
        else $error("flag read wrong");

endmodule : cmbp_top

// File: test/cmbp_frame_model.sv
// Frame engine model that drives the transmit side of the buffer block.
`timescale 1ns/1ps
module cmbp_frame_model (
    input  wire logic       clk_sys_i, // System clock.
    output logic            sof_o,     // About to send a start bit.
    output logic            done_o,    // Frame sent successfully.
    output logic            lost_o,    // Frame lost or errored.
    output logic [2:0]      idx_o      // Payload byte asked for.
);
    // Quiet lines from time zero so the block sees no stray request.
    initial begin
        sof_o = 1'b0;
        done_o = 1'b0;
        lost_o = 1'b0;
        idx_o = 3'h0;
    end
    // Pulse the pre-start strobe for one cycle; candidates are taken.
    task automatic start(input logic [2:0] k);
        @(posedge clk_sys_i) sof_o <= 1'b1;
        idx_o <= k;
        @(posedge clk_sys_i) sof_o <= 1'b0;
    endtask : start
    // End the frame; a lost frame stays queued for a later retry.
    task automatic finish(input logic ok);
        @(posedge clk_sys_i) {done_o, lost_o} <= {ok, !ok};
        @(posedge clk_sys_i) {done_o, lost_o} <= 2'b00;
    endtask : finish
endmodule : cmbp_frame_model

// File: test/tb_cmbp_top.sv
// Self-checking bench for the transmit message buffer block.
`timescale 1ns/1ps
module tb_cmbp_top;
    import cmbp_pkg::*;
    logic clk_sys_i, rst_n_i, wr_i, rd_i;
    logic [ADDR_W-1:0] addr_i;
    logic [7:0] wr_data_i, rd_data_o, tx_byte_o, rv;
    logic sof, done, lost, tx_valid_o, tx_ide_o, tx_rtr_o;
    logic [2:0] idx, tx_empty_o;
    logic [IDX_W-1:0] tx_buf_o;
    logic [EXT_ID_W-1:0] tx_id_o;
    logic [DLC_W-1:0] tx_dlc_o, tx_count_o;
    int err_total = 0, num_checks = 0;
    cmbp_top cmbp_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .tx_sof_i(sof), .tx_done_i(done),
        .tx_abandon_i(lost), .tx_byte_idx_i(idx), .tx_valid_o(tx_valid_o),
        .tx_buf_o(tx_buf_o), .tx_id_o(tx_id_o), .tx_ide_o(tx_ide_o),
        .tx_rtr_o(tx_rtr_o), .tx_dlc_o(tx_dlc_o), .tx_count_o(tx_count_o),
        .tx_byte_o(tx_byte_o), .tx_empty_o(tx_empty_o));
    cmbp_frame_model cmbp_frame_model_i (.clk_sys_i(clk_sys_i),
        .sof_o(sof), .done_o(done), .lost_o(lost), .idx_o(idx));
    // ==================================================================
    // Clock, bus tasks and comparison
    // ==================================================================
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // Compare after the edge's updates have landed.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) {wr_i, addr_i, wr_data_i} <= {1'b1, a, d};
        @(posedge clk_sys_i) wr_i <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_sys_i) {rd_i, addr_i} <= {1'b1, a};
        @(posedge clk_sys_i) rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask : rd
    // Fill the empty buffer in one-hot m, then queue it by clearing its flag.
    task automatic load(input logic [2:0] m, input logic [7:0] b0, b1, ln,
                        input logic [7:0] pr, p7);
        wr(REG_TX_SEL, {5'b0, m});
        wr(5'h00, b0);
        wr(5'h01, b1);
        wr(5'h0b, p7);
        wr(5'h0c, ln);
        wr(5'h0d, pr); // Written while empty and selected.
        wr(REG_TX_FLAG, {5'b0, m});
    endtask : load
    // Start a frame and judge the header and the last payload byte.
    task automatic frame(input int b, input logic [31:0] id,
                         input logic [4:0] ir, input logic [3:0] dl, ct,
                         input logic [7:0] p7);
        cmbp_frame_model_i.start(3'h7);
        #1 chk(tx_valid_o, 1);
        chk(tx_buf_o, b);
        chk(tx_id_o, id);
        chk({tx_ide_o, tx_rtr_o}, ir);
        chk({tx_dlc_o, tx_count_o}, {dl, ct});
        @(posedge clk_sys_i) #1 chk(tx_byte_o, p7);
    endtask : frame
    task automatic stop_test;
        $display("checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    // Cut a hang short well beyond the hundred or so cycles the run needs.
    initial begin
        #2000000 err_total++;
        stop_test();
    end
    // ==================================================================
    // Main sequence
    // ==================================================================
    initial begin
        {rst_n_i, wr_i, rd_i, addr_i, wr_data_i} = 16'h0000;
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1 chk(tx_empty_o, 3'h7);
        rd(REG_TX_FLAG, rv);
        chk(rv, 8'h07);
        // A full mask keeps only the lowest empty buffer in the window.
        wr(REG_TX_SEL, 8'h07);
        rd(REG_TX_SEL, rv);
        chk(rv, 8'h01);
        rd(5'h0d, rv);
        chk(rv, 8'h00);
        cmbp_frame_model_i.start(3'h0);
        #1 chk(tx_valid_o, 0);
        // Unsigned compare: 0x80 loses to 0x05, tie goes to buffer 1.
        load(3'h1, 8'h12, 8'h2f, 8'h05, 8'h80, 8'h11);
        load(3'h2, 8'hab, 8'he7, 8'h09, 8'h05, 8'h22);
        load(3'h4, 8'h00, 8'h10, 8'h03, 8'h05, 8'h33);
        // Buffer 2 is queued, so this priority is refused and 1 still wins.
        wr(5'h0d, 8'h00);
        frame(1, 32'h55f, 5'h00, 4'h9, 4'h8, 8'h22);
        cmbp_frame_model_i.finish(1'b1);
        #1 chk({tx_valid_o, tx_empty_o}, 4'h2);
        // Remote frame keeps its code but sends nothing; retried after loss.
        frame(2, 32'h000, 5'h01, 4'h3, 4'h0, 8'h33);
        cmbp_frame_model_i.finish(1'b0);
        frame(2, 32'h000, 5'h01, 4'h3, 4'h0, 8'h33);
        cmbp_frame_model_i.finish(1'b1);
        frame(0, 32'h2478000, 5'h02, 4'h5, 4'h5, 8'h11);
        cmbp_frame_model_i.finish(1'b1);
        #1 chk(tx_empty_o, 3'h7);
        stop_test();
    end
endmodule : tb_cmbp_top
